// >>> rtl/mrau_top.sv
/*
  Mode-register access unit: command decode, read bursts, register writes,
  calibration patterns and temperature status.
  Assumes ck is the controller's link clock and banks_active comes from the
  bank logic on clk; dq and dqs pins are resolved outside from the enables.
*/
`timescale 1ns/100ps
`default_nettype none
module mrau_top #(
  parameter int TSI_CYC = mrau_pkg::TSI_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ck,
  input  wire logic        cs_n,
  input  wire logic        cke,
  input  wire logic [9:0]  ca,
  input  wire logic [2:0]  temp_sensor,
  input  wire logic        low_power,
  input  wire logic        banks_active,
  output logic      [31:0] dq_o,
  output logic             dq_oe_n,
  output logic             dqs_o,
  output logic             dqs_oe_n,
  output logic      [2:0]  temp_status,
  output logic             mrw_rejected,
  output logic             mr_busy
);
  localparam int LAT_P1 = mrau_pkg::READ_LAT + 1;

  // ---------------- system clock side: temperature sampling ----------------
  logic [2:0]  temp_m;
  logic [2:0]  temp_s;
  logic [2:0]  temp_q;
  logic        lp_m;
  logic        lp_s;
  logic        lp_q;
  logic [31:0] tsi_cnt;
  logic        upd_pend;
  logic        req;
  logic        ack_l;
  logic        ack_m;
  logic        ack_s;
  logic        launch;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp_m <= 3'h0;
      temp_s <= 3'h0;
      temp_q <= 3'h0;
      lp_m   <= 1'b0;
      lp_s   <= 1'b0;
      lp_q   <= 1'b0;
      ack_m  <= 1'b0;
      ack_s  <= 1'b0;
    end
    else
    begin
      temp_m <= temp_sensor;
      temp_s <= temp_m;
      temp_q <= temp_s;
      lp_m   <= low_power;
      lp_s   <= lp_m;
      lp_q   <= lp_s;
      ack_m  <= ack_l;
      ack_s  <= ack_m;
    end
  end

  // a new sample only launches once the link side took the last one;
  // the synced code must hold two cycles, so a skewed multi-bit change is never taken
  assign launch = upd_pend && (req == ack_s) && (temp_s == temp_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tsi_cnt  <= 32'h0;
      upd_pend <= 1'b1;
    end
    else
    begin
      if (tsi_cnt == 32'(TSI_CYC - 1) || (lp_q && !lp_s))
      begin
        tsi_cnt  <= 32'h0;
        upd_pend <= 1'b1;
      end
      else
      begin
        tsi_cnt <= tsi_cnt + 32'h1;
        if (launch)
          upd_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp_status <= mrau_pkg::TEMP_RST;
      req         <= 1'b0;
    end
    else if (launch)
    begin
      temp_status <= temp_s;
      req         <= ~req;
    end
  end

  // ---------------- link clock side ----------------
  logic                  req_m;
  logic                  req_s;
  logic [2:0]            temp_link;
  logic                  bank_m;
  logic                  bank_s;
  logic [9:0]            ca_f;
  mrau_pkg::mrau_cmd_t   cmd_q;
  mrau_pkg::mrau_state_t state;
  logic [3:0]            per_cnt;
  logic [7:0]            mr_mem [256];
  logic                  rd_take;
  logic                  wr_take;
  logic [7:0]            act_addr;
  logic [7:0]            act_data;
  logic                  act_ro;
  logic                  pend;
  logic [3:0]            wait_cnt;
  logic [2:0]            beats;
  logic [7:0]            rd_addr;
  logic [7:0]            rd_byte;
  logic                  burst_busy;
  logic                  start;
  logic                  out_en;
  logic [1:0]            beat_idx;
  logic [31:0]           next_dq;

  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_m     <= 1'b0;
      req_s     <= 1'b0;
      ack_l     <= 1'b0;
      temp_link <= mrau_pkg::TEMP_RST;
      bank_m    <= 1'b0;
      bank_s    <= 1'b0;
    end
    else
    begin
      req_m  <= req;
      req_s  <= req_m;
      bank_m <= banks_active;
      bank_s <= bank_m;
      // temp_status is held still until ack returns, so it is safe to take
      if (req_s != ack_l)
      begin
        temp_link <= temp_status;
        ack_l     <= req_s;
      end
    end
  end

  // falling-edge half of the command word
  always_ff @(negedge ck or negedge rst_n)
  begin
    if (!rst_n)
      ca_f <= 10'h0;
    else
      ca_f <= ca;
  end

  assign burst_busy = pend || (beats != 3'h0);
  assign rd_take = (state == mrau_pkg::MRAU_IDLE) && cke && !cs_n && !burst_busy
                   && (ca[3:0] == mrau_pkg::CMD_RD_CODE);
  assign wr_take = (state == mrau_pkg::MRAU_IDLE) && cke && !cs_n
                   && (ca[3:0] == mrau_pkg::CMD_WR_CODE);

  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
      cmd_q <= '0;
    else
    begin
      cmd_q.rd   <= rd_take;
      cmd_q.wr   <= wr_take;
      cmd_q.ca_r <= ca;
    end
  end

  assign act_addr = {ca_f[1:0], cmd_q.ca_r[9:4]};
  assign act_data = ca_f[9:2];
  assign act_ro   = (act_addr == mrau_pkg::REG_TEMP) || (act_addr == mrau_pkg::REG_CAL_A)
                    || (act_addr == mrau_pkg::REG_CAL_B);

  // commands other than the one taken are ignored until the period ends
  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= mrau_pkg::MRAU_IDLE;
      per_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        mrau_pkg::MRAU_IDLE:
        begin
          if (rd_take)
          begin
            state   <= mrau_pkg::MRAU_RD;
            per_cnt <= 4'(mrau_pkg::MRR_PERIOD - 1);
          end
          else if (wr_take)
          begin
            state   <= mrau_pkg::MRAU_WR;
            per_cnt <= 4'(mrau_pkg::MRW_PERIOD - 1);
          end
        end
        mrau_pkg::MRAU_RD, mrau_pkg::MRAU_WR:
        begin
          per_cnt <= per_cnt - 4'h1;
          if (per_cnt == 4'h1)
            state <= mrau_pkg::MRAU_IDLE;
        end
        default:
          state <= mrau_pkg::MRAU_IDLE;
      endcase
    end
  end

  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
      mr_busy <= 1'b0;
    else
      mr_busy <= rd_take || wr_take || (state != mrau_pkg::MRAU_IDLE && per_cnt != 4'h1)
                 || burst_busy;
  end

  // banks active or a read-only target: the write is dropped
  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 256; i++)
        mr_mem[i] <= mrau_pkg::MR_RST;
    end
    else if (cmd_q.wr && !bank_s && !act_ro)
      mr_mem[act_addr] <= act_data;
  end

  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
      mrw_rejected <= 1'b0;
    else
      mrw_rejected <= cmd_q.wr && bank_s;
  end

  // read burst: latency wait, then four beats
  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend     <= 1'b0;
      wait_cnt <= 4'h0;
      beats    <= 3'h0;
      rd_addr  <= 8'h0;
      rd_byte  <= 8'h0;
    end
    else if (cmd_q.rd)
    begin
      pend     <= 1'b1;
      wait_cnt <= 4'(mrau_pkg::READ_LAT - 1);
      rd_addr  <= act_addr;
      rd_byte  <= (act_addr == mrau_pkg::REG_TEMP) ? {5'h00, temp_link} : mr_mem[act_addr];
    end
    else if (start)
    begin
      pend  <= 1'b0;
      beats <= 3'(mrau_pkg::BURST_BEATS);
    end
    else
    begin
      if (pend)
        wait_cnt <= wait_cnt - 4'h1;
      if (beats != 3'h0)
        beats <= beats - 3'h1;
    end
  end

  assign start    = pend && (wait_cnt == 4'h1);
  assign out_en   = start || (beats > 3'h1);
  assign beat_idx = start ? 2'h0 : 2'(3'(mrau_pkg::BURST_BEATS) - beats + 3'h1);

  always_comb
  begin
    next_dq = 32'h0;
    if (rd_addr == mrau_pkg::REG_CAL_A)
      next_dq = {32{mrau_pkg::PAT_A[beat_idx]}};
    else if (rd_addr == mrau_pkg::REG_CAL_B)
      next_dq = {32{mrau_pkg::PAT_B[beat_idx]}};
    else if (beat_idx == 2'h0)
      next_dq = {24'h0, rd_byte};
  end

  // strobes toggle for every read, reserved targets included
  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_o     <= 32'h0;
      dq_oe_n  <= 1'b1;
      dqs_o    <= 1'b0;
      dqs_oe_n <= 1'b1;
    end
    else
    begin
      dq_o     <= out_en ? next_dq : 32'h0;
      dq_oe_n  <= !out_en;
      dqs_o    <= out_en ? !dqs_o : 1'b0;
      dqs_oe_n <= !out_en;
    end
  end

  // ---------------- checks ----------------
  logic [7:0] chk_addr;
  logic [7:0] chk_data;
  logic [7:0] chk_old;
  logic       chk_ok;
  logic       chk_cal;

  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chk_addr <= 8'h0;
      chk_data <= 8'h0;
      chk_old  <= 8'h0;
      chk_ok   <= 1'b0;
    end
    else
    begin
      chk_addr <= act_addr;
      chk_data <= act_data;
      chk_old  <= mr_mem[act_addr];
      chk_ok   <= cmd_q.wr && !bank_s && !act_ro;
    end
  end

  assign chk_cal = (rd_addr == mrau_pkg::REG_CAL_A) || (rd_addr == mrau_pkg::REG_CAL_B);

  sequence s_four_beats;
    !dq_oe_n [*4] ##1 dq_oe_n;
  endsequence

  sequence s_rd_period;
    state == mrau_pkg::MRAU_RD ##1 state == mrau_pkg::MRAU_IDLE;
  endsequence

  sequence s_wr_period;
    (state == mrau_pkg::MRAU_WR) [*4] ##1 state == mrau_pkg::MRAU_IDLE;
  endsequence

  a_burst_four_beats: assert property (@(posedge ck) disable iff (!rst_n)
    $fell(dq_oe_n) |-> s_four_beats)
    else $error("read burst is not four beats");

  a_mrr_cmd_period: assert property (@(posedge ck) disable iff (!rst_n)
    rd_take |=> s_rd_period)
    else $error("read command period is not two cycles");

  a_mrw_cmd_period: assert property (@(posedge ck) disable iff (!rst_n)
    wr_take |=> s_wr_period)
    else $error("write command period wrong");

  a_read_latency: assert property (@(posedge ck) disable iff (!rst_n)
    rd_take |-> ##LAT_P1 (!dq_oe_n && $fell(dq_oe_n)))
    else $error("first beat not at read latency");

  a_low_lane_only: assert property (@(posedge ck) disable iff (!rst_n)
    ($fell(dq_oe_n) && !chk_cal) |-> (dq_o[31:8] == 24'h0 && dq_o[7:0] == rd_byte))
    else $error("register byte not on lowest lane");

  a_cal_lane_copy: assert property (@(posedge ck) disable iff (!rst_n)
    (!dq_oe_n && chk_cal) |-> (dq_o == {32{dq_o[0]}}))
    else $error("calibration lines differ within lane");

  a_cal_pattern_a: assert property (@(posedge ck) disable iff (!rst_n)
    ($fell(dq_oe_n) && rd_addr == mrau_pkg::REG_CAL_A) |-> dq_o[0] ##1 !dq_o[0]
      ##1 dq_o[0] ##1 !dq_o[0])
    else $error("pattern a wrong");

  a_write_lands: assert property (@(posedge ck) disable iff (!rst_n)
    chk_ok |-> (mr_mem[chk_addr] == chk_data))
    else $error("register write not in effect");

  a_ro_unchanged: assert property (@(posedge ck) disable iff (!rst_n)
    ($past(cmd_q.wr) && $past(act_ro)) |-> (mr_mem[chk_addr] == chk_old))
    else $error("read-only register changed");

  a_bank_reject: assert property (@(posedge ck) disable iff (!rst_n)
    (cmd_q.wr && bank_s) |=> mrw_rejected)
    else $error("write with banks active not rejected");

  a_temp_refresh: assert property (@(posedge clk) disable iff (!rst_n)
    (tsi_cnt == 32'(TSI_CYC - 1)) |=> upd_pend)
    else $error("temperature update not requested");
endmodule
`default_nettype wire

// >>> rtl/mrau_pkg.sv
/*
  Constants, types and encodings of the mode-register access unit.
  Assumes a 20 MHz system clock and a link clock from the memory controller.
*/
// Behaviour
// - Read command: select low, address bits 0..2 low and bit 3 high.
// - Read command period is two link cycles; other commands ignored meanwhile.
// - Every register read answers with exactly four data beats.
// - Register value on lowest byte lane, first beat only; rest undefined.
// - Temperature status refreshed from the sensor at most 32 ms apart.
// - After self refresh or power down, temperature status is fresh.
// - Temperature code sits in bits 2..0; 011b means above 85 degrees.
// - Calibration reads return 1,0,1,0 or 0,0,1,1 on each lane's lowest line.
// - During calibration bursts all lines of a lane copy its lowest line.
// - Write command: select low, address bits 0..3 all low.
// - Register number from falling bits 1..0, rising 9..4; data falling 9..2.
// - Writes to read-only registers change nothing.
// - Reads legal in any bank state; writes illegal with banks active.
// - Reads of reserved or write-only registers still toggle strobes.
package mrau_pkg;
  localparam int CLK_HZ      = 20_000_000;
  localparam int TSI_MS      = 32;
  localparam int TSI_CYC     = TSI_MS * (CLK_HZ / 1000);
  localparam int READ_LAT    = 3;
  localparam int MRR_PERIOD  = 2;
  localparam int MRW_PERIOD  = 5;
  localparam int BURST_BEATS = 4;

  localparam logic [3:0] CMD_RD_CODE = 4'h8;
  localparam logic [3:0] CMD_WR_CODE = 4'h0;
  localparam logic [7:0] REG_TEMP    = 8'h04;
  localparam logic [7:0] REG_CAL_A   = 8'h20;
  localparam logic [7:0] REG_CAL_B   = 8'h28;
  localparam logic [3:0] PAT_A       = 4'h5;
  localparam logic [3:0] PAT_B       = 4'hC;
  localparam logic [2:0] TEMP_RST    = 3'h0;
  localparam logic [7:0] MR_RST      = 8'h00;

  typedef enum logic [1:0]
  {
    MRAU_IDLE = 2'h0,
    MRAU_RD   = 2'h1,
    MRAU_WR   = 2'h2
  } mrau_state_t;

  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [9:0] ca_r;
  } mrau_cmd_t;
endpackage

// >>> dv/mrau_ctrl_model.sv
/*
  Controller model: runs the link clock, issues register commands, captures bursts.
  Assumes the device answers with the handed-over read latency.
*/
`timescale 1ns/100ps
`default_nettype none
module mrau_ctrl_model #(
  parameter int SKEW_CYC = 1
) (
  output logic             ck,
  output logic             cs_n,
  output logic             cke,
  output logic      [9:0]  ca,
  input  wire logic [31:0] dq_o,
  input  wire logic        dq_oe_n,
  input  wire logic        dqs_o,
  input  wire logic        dqs_oe_n
);
  localparam int RD_GAP = mrau_pkg::READ_LAT + SKEW_CYC + 2 + 1;
  logic [31:0] beat [4];
  logic [3:0]  oe;
  logic [3:0]  stb;
  logic        tail;

  initial
  begin
    ck = 1'b0;
    cs_n = 1'b1;
    cke = 1'b1;
    ca = 10'h3FF;
    #7;
    forever #40 ck = ~ck;
  end

  // only register commands go out, so array burst spacing never applies
  task automatic cmd(input logic [3:0] code, input logic [7:0] num, input logic [7:0] data);
    @(negedge ck);
    #1;
    cs_n = 1'b0;
    ca = {num[5:0], code};
    @(posedge ck);
    #1;
    ca = {data, num[7:6]};
  endtask

  // deselect; the bus flips so a stale command never looks valid
  task automatic nop(input int n);
    repeat (n)
    begin
      @(negedge ck);
      #1;
      cs_n = 1'b1;
      ca = ~ca;
    end
  endtask

  task automatic set_cke(input logic v);
    @(negedge ck);
    #1;
    cke = v;
  endtask

  // done counts edges already spent after the read edge
  task automatic take_burst(input int done);
    repeat (mrau_pkg::READ_LAT - 1 - done) @(posedge ck);
    for (int i = 0; i < mrau_pkg::BURST_BEATS; i++)
    begin
      @(posedge ck);
      #1;
      beat[i] = dq_o;
      oe[i] = dq_oe_n | dqs_oe_n;
      stb[i] = dqs_o;
    end
    @(posedge ck);
    #1;
    tail = dq_oe_n;
    // nothing is issued until the burst and the write gap are over
    repeat (RD_GAP > 7 ? RD_GAP - 7 : 0) @(posedge ck);
  endtask
endmodule
`default_nettype wire

// >>> dv/mrau_tb_top.sv
/*
  Testbench of the mode-register access unit: commands, bursts, temperature.
  Assumes the controller model drives the link side.
*/
`timescale 1ns/100ps
`default_nettype none
module mrau_tb_top;
  localparam int TSI = 200;
  logic        clk;
  logic        rst_n;
  logic        ck;
  logic        cs_n;
  logic        cke;
  logic [9:0]  ca;
  logic [2:0]  temp_sensor;
  logic        low_power;
  logic        banks_active;
  logic [31:0] dq_o;
  logic        dq_oe_n;
  logic        dqs_o;
  logic        dqs_oe_n;
  logic [2:0]  temp_status;
  logic        mrw_rejected;
  logic        mr_busy;
  int          miscompares;
  int          check_count;

  mrau_top #(.TSI_CYC(TSI)) mrau_top_inst (.clk(clk), .rst_n(rst_n), .ck(ck), .cs_n(cs_n),
    .cke(cke), .ca(ca), .temp_sensor(temp_sensor), .low_power(low_power),
    .banks_active(banks_active), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o),
    .dqs_oe_n(dqs_oe_n), .temp_status(temp_status), .mrw_rejected(mrw_rejected),
    .mr_busy(mr_busy));

  mrau_ctrl_model mrau_ctrl_model_inst (.ck(ck), .cs_n(cs_n), .cke(cke), .ca(ca),
    .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_burst(input logic [7:0] b, input logic cal, input logic [3:0] pat);
    logic [31:0] exp;
    for (int i = 0; i < 4; i++)
    begin
      exp = cal ? {32{pat[i]}} : (i == 0 ? {24'h0, b} : 32'h0);
      check("read beat", exp, mrau_ctrl_model_inst.beat[i]);
    end
    check("burst enables", 32'h0, {28'h0, mrau_ctrl_model_inst.oe});
    check("burst strobe", 32'h5, {28'h0, mrau_ctrl_model_inst.stb});
    check("enable after burst", 32'h1, {31'h0, mrau_ctrl_model_inst.tail});
  endtask

  task automatic mr_read(input logic [7:0] num, input logic [7:0] b, input logic cal,
                         input logic [3:0] pat);
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_RD_CODE, num, 8'h00);
    check("busy in read", 32'h1, {31'h0, mr_busy});
    mrau_ctrl_model_inst.nop(1);
    mrau_ctrl_model_inst.take_burst(0);
    check_burst(b, cal, pat);
  endtask

  // leaves the write period with no-operations, next command lands at C+5
  task automatic mr_write(input logic [7:0] num, input logic [7:0] data, input logic rej);
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_WR_CODE, num, data);
    mrau_ctrl_model_inst.nop(1);
    // the refusal pulse stands for the one cycle after C+1
    @(posedge ck);
    #1;
    check("write refused", {31'h0, rej}, {31'h0, mrw_rejected});
    check("busy in write", 32'h1, {31'h0, mr_busy});
    mrau_ctrl_model_inst.nop(3);
    @(posedge ck);
    #1;
    check("busy after write", 32'h0, {31'h0, mr_busy});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    temp_sensor = 3'h0;
    low_power = 1'b0;
    banks_active = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    mr_read(8'h3F, mrau_pkg::MR_RST, 1'b0, 4'h0);
    mr_write(8'hD3, 8'hA5, 1'b0);
    mr_read(8'hD3, 8'hA5, 1'b0, 4'h0);
    // second write lands inside the write period and must be dropped
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_WR_CODE, 8'hD3, 8'h11);
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_WR_CODE, 8'hD3, 8'h22);
    mrau_ctrl_model_inst.nop(4);
    mr_read(8'hD3, 8'h11, 1'b0, 4'h0);
    // write inside the read period is dropped and the burst runs whole
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_RD_CODE, 8'hD3, 8'h00);
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_WR_CODE, 8'hD3, 8'h5A);
    mrau_ctrl_model_inst.nop(1);
    mrau_ctrl_model_inst.take_burst(1);
    check_burst(8'h11, 1'b0, 4'h0);
    mr_read(8'hD3, 8'h11, 1'b0, 4'h0);
    // with the clock enable low a read is not taken
    mrau_ctrl_model_inst.set_cke(1'b0);
    mrau_ctrl_model_inst.cmd(mrau_pkg::CMD_RD_CODE, 8'hD3, 8'h00);
    check("busy with cke low", 32'h0, {31'h0, mr_busy});
    mrau_ctrl_model_inst.nop(1);
    mrau_ctrl_model_inst.take_burst(0);
    check("enables with cke low", 32'hF, {28'h0, mrau_ctrl_model_inst.oe});
    mrau_ctrl_model_inst.set_cke(1'b1);
    @(negedge clk);
    banks_active = 1'b1;
    repeat (4) @(posedge ck);
    mr_write(8'hD3, 8'h77, 1'b1);
    mr_read(8'hD3, 8'h11, 1'b0, 4'h0);
    @(negedge clk);
    banks_active = 1'b0;
    repeat (4) @(posedge ck);
    mr_write(mrau_pkg::REG_TEMP, 8'hFF, 1'b0);
    mr_write(mrau_pkg::REG_CAL_A, 8'hFF, 1'b0);
    mr_write(mrau_pkg::REG_CAL_B, 8'h00, 1'b0);
    mr_read(mrau_pkg::REG_CAL_A, 8'h00, 1'b1, mrau_pkg::PAT_A);
    mr_read(mrau_pkg::REG_CAL_B, 8'h00, 1'b1, mrau_pkg::PAT_B);
    @(negedge clk);
    temp_sensor = 3'h3;
    repeat (TSI + 10) @(negedge clk);
    check("temp status", 32'h3, {29'h0, temp_status});
    mr_read(mrau_pkg::REG_TEMP, 8'h03, 1'b0, 4'h0);
    @(negedge clk);
    temp_sensor = 3'h5;
    low_power = 1'b1;
    repeat (5) @(negedge clk);
    low_power = 1'b0;
    repeat (20) @(negedge clk);
    check("temp after wake", 32'h5, {29'h0, temp_status});
    // second reset in mid-run: outputs and registers return to reset values
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    check("enable in reset", 32'h1, {31'h0, dq_oe_n});
    check("busy in reset", 32'h0, {31'h0, mr_busy});
    check("temp in reset", {29'h0, mrau_pkg::TEMP_RST}, {29'h0, temp_status});
    rst_n = 1'b1;
    mr_read(8'hD3, mrau_pkg::MR_RST, 1'b0, 4'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
